// ### verilog/tif_pkg.sv
// package of the transceiver interrupt flag block: register map, field layout, reset values
// assumes an AXI4-Lite master with 32-bit data; each 8-bit register sits in the low byte of a word
package tif_pkg;

  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned IDX_W     = 6;
  localparam int unsigned REG_W     = 8;
  localparam int unsigned TIMER_W   = 16;
  localparam int unsigned ERR_W     = 8;
  localparam int unsigned EDGE_N    = 5;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] PRI_EN_IDX  = 6'h02;
  localparam logic [IDX_W-1:0] SEC_EN_IDX  = 6'h03;
  localparam logic [IDX_W-1:0] PRI_REQ_IDX = 6'h04;
  localparam logic [IDX_W-1:0] SEC_REQ_IDX = 6'h05;
  localparam logic [IDX_W-1:0] STATUS_IDX  = 6'h10;

  // reset values
  localparam logic [REG_W-1:0] PRI_EN_RST  = 8'h80;
  localparam logic [REG_W-1:0] SEC_EN_RST  = 8'h00;
  localparam logic [REG_W-1:0] PRI_REQ_RST = 8'h14;
  localparam logic [REG_W-1:0] SEC_REQ_RST = 8'h00;

  // writable bits of the secondary enable; bits 6 and 5 are reserved and read zero
  localparam logic [REG_W-1:0] SEC_EN_MASK = 8'h9F;

  // field positions
  localparam int unsigned SEL_BIT      = 7;
  localparam int unsigned F_TX         = 6;
  localparam int unsigned F_RX         = 5;
  localparam int unsigned F_IDLE       = 4;
  localparam int unsigned F_HIGH       = 3;
  localparam int unsigned F_LOW        = 2;
  localparam int unsigned F_ERR        = 1;
  localparam int unsigned F_TIMER      = 0;
  localparam int unsigned F_SECURE     = 4;
  localparam int unsigned F_MODE       = 3;
  localparam int unsigned F_CRC        = 2;
  localparam int unsigned F_FON        = 1;
  localparam int unsigned F_FOFF       = 0;
  localparam int unsigned PRI_FLAGS    = 7;
  localparam int unsigned SEC_FLAGS    = 5;
  localparam int unsigned ST_IRQ       = 0;
  localparam int unsigned ST_MODE_ACT  = 1;
  localparam int unsigned ST_FIELD     = 2;

  // edge detector lanes
  localparam int unsigned E_SECURE = 0;
  localparam int unsigned E_HIGH   = 1;
  localparam int unsigned E_LOW    = 2;
  localparam int unsigned E_TZERO  = 3;
  localparam int unsigned E_FIELD  = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### verilog/tif_reg_if.sv
// register access carrier between the bus slave and the flag core
// assumes one clock; the write strobe is a one-cycle pulse, read data is combinational
`timescale 1ns/10ps
interface tif_reg_if;
  logic                       wr_en;
  logic [tif_pkg::IDX_W-1:0]  wr_idx;
  logic [tif_pkg::REG_W-1:0]  wr_data;
  logic                       wr_hit;
  logic [tif_pkg::IDX_W-1:0]  rd_idx;
  logic [tif_pkg::REG_W-1:0]  rd_data;
  logic                       rd_hit;

  modport bus  (output wr_en, wr_idx, wr_data, rd_idx, input wr_hit, rd_data, rd_hit);
  modport core (input wr_en, wr_idx, wr_data, rd_idx, output wr_hit, rd_data, rd_hit);
endinterface

// ### verilog/tif_axil_slave.sv
// AXI4-Lite slave front end: takes address and data in either order, one access of each kind
// assumes the core answers hit and read data combinationally from the index
`timescale 1ns/10ps
module tif_axil_slave (
  input  wire logic                        clk_i,
  input  wire logic                        resetn_i,
  input  wire logic [tif_pkg::ADDR_W-1:0]  awaddr_i,
  input  wire logic                        awvalid_i,
  output logic                             awready_o,
  input  wire logic [31:0]                 wdata_i,
  input  wire logic [3:0]                  wstrb_i,
  input  wire logic                        wvalid_i,
  output logic                             wready_o,
  output logic [1:0]                       bresp_o,
  output logic                             bvalid_o,
  input  wire logic                        bready_i,
  input  wire logic [tif_pkg::ADDR_W-1:0]  araddr_i,
  input  wire logic                        arvalid_i,
  output logic                             arready_o,
  output logic [31:0]                      rdata_o,
  output logic [1:0]                       rresp_o,
  output logic                             rvalid_o,
  input  wire logic                        rready_i,
  tif_reg_if.bus                           rif
);
  logic                       awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
  logic                       bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]                 bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]                rdata_q, rdata_d;
  logic [tif_pkg::IDX_W-1:0]  awidx_q, awidx_d, aridx_q, aridx_d;
  logic [tif_pkg::REG_W-1:0]  wdata_q, wdata_d;
  logic                       wlane_q, wlane_d;
  logic                       do_wr, do_rd;

  // a ready flop low means that channel holds a captured item
  assign do_wr       = !awready_q && !wready_q && !bvalid_q;
  assign do_rd       = !arready_q && !rvalid_q;
  assign rif.wr_en   = do_wr && wlane_q;
  assign rif.wr_idx  = awidx_q;
  assign rif.wr_data = wdata_q;
  assign rif.rd_idx  = aridx_q;

  always_comb begin
    awready_d = awready_q;
    wready_d  = wready_q;
    arready_d = arready_q;
    bvalid_d  = bvalid_q;
    rvalid_d  = rvalid_q;
    bresp_d   = bresp_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    awidx_d   = awidx_q;
    aridx_d   = aridx_q;
    wdata_d   = wdata_q;
    wlane_d   = wlane_q;
    if (awvalid_i && awready_q) begin
      awready_d = 1'b0;
      awidx_d   = awaddr_i[tif_pkg::ADDR_W-1:2];
    end
    if (wvalid_i && wready_q) begin
      wready_d = 1'b0;
      wdata_d  = wdata_i[tif_pkg::REG_W-1:0];
      wlane_d  = wstrb_i[0];
    end
    if (do_wr) begin
      awready_d = 1'b1;
      wready_d  = 1'b1;
      bvalid_d  = 1'b1;
      bresp_d   = rif.wr_hit ? tif_pkg::RESP_OKAY : tif_pkg::RESP_SLVERR;
    end
    if (bvalid_q && bready_i) begin
      bvalid_d = 1'b0;
    end
    if (arvalid_i && arready_q) begin
      arready_d = 1'b0;
      aridx_d   = araddr_i[tif_pkg::ADDR_W-1:2];
    end
    if (do_rd) begin
      rvalid_d = 1'b1;
      rdata_d  = {24'h000000, rif.rd_data};
      rresp_d  = rif.rd_hit ? tif_pkg::RESP_OKAY : tif_pkg::RESP_SLVERR;
    end
    if (rvalid_q && rready_i) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      arready_q <= 1'b1;
      bvalid_q  <= 1'b0;
      rvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      rresp_q   <= 2'h0;
      rdata_q   <= 32'h00000000;
      awidx_q   <= 6'h00;
      aridx_q   <= 6'h00;
      wdata_q   <= 8'h00;
      wlane_q   <= 1'b0;
    end else begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
      arready_q <= arready_d;
      bvalid_q  <= bvalid_d;
      rvalid_q  <= rvalid_d;
      bresp_q   <= bresp_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      awidx_q   <= awidx_d;
      aridx_q   <= aridx_d;
      wdata_q   <= wdata_d;
      wlane_q   <= wlane_d;
    end
  end

  assign awready_o = awready_q;
  assign wready_o  = wready_q;
  assign arready_o = arready_q;
  assign bvalid_o  = bvalid_q;
  assign bresp_o   = bresp_q;
  assign rvalid_o  = rvalid_q;
  assign rresp_o   = rresp_q;
  assign rdata_o   = rdata_q;
endmodule // tif_axil_slave

// ### verilog/tif_edge_detect.sv
// per-lane rise and fall detector on levels that are already synchronous to clk_i
// assumes the levels are low at reset release; a lane high then reports one rise
`timescale 1ns/10ps
module tif_edge_detect (
  input  wire logic                        clk_i,
  input  wire logic                        resetn_i,
  input  wire logic [tif_pkg::EDGE_N-1:0]  level_i,
  output logic      [tif_pkg::EDGE_N-1:0]  rise_o,
  output logic      [tif_pkg::EDGE_N-1:0]  fall_o
);
  logic [tif_pkg::EDGE_N-1:0] prev_q, prev_d;

  generate
    for (genvar i = 0; i < tif_pkg::EDGE_N; i++) begin : g_lane
      assign rise_o[i] = level_i[i] && !prev_q[i];
      assign fall_o[i] = !level_i[i] && prev_q[i];
    end
  endgenerate

  always_comb begin
    prev_d = level_i;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_q <= 5'h00;
    end else begin
      prev_q <= prev_d;
    end
  end
endmodule // tif_edge_detect

// ### verilog/tif_irq_top.sv
// transceiver interrupt flag block: enable and request registers, event capture, pin drive
// assumes event inputs synchronous to clk_i; pulses last one cycle, levels are steady
// Function
// - drive-select 1 drives the pin push-pull, 0 makes it open drain.
// - secondary enable bits 4..0 gate secure edge, mode, CRC, field on, field off.
// - secondary enable resets to zero; bits 6 and 5 are reserved.
// - primary request write: bit 7 chooses set or clear of marked flags.
// - secondary request write: bit 7 chooses set or clear of marked flags.
// - primary request resets with only idle and low-alert flags set.
// - transmit-done flag sets after the last transmitted bit leaves.
// - receive-done sets at valid stream end; with filter, only if buffer holds data.
// - idle flag sets when a command ends by itself.
// - an unknown command start forces command to idle and sets idle flag.
// - a host-started idle command does not set the idle flag.
// - buffer-high flag latches on rising high level, held until cleared.
// - buffer-low flag latches on rising low level, held until cleared.
// - error flag sets whenever any error status bit is set.
// - timer flag sets when the timer count reaches zero.
// - secure-edge flag sets on rising or falling secure input edge.
// - mode-detected flag sets when the data mode detector finds the mode.
// - mode detector starts on auto anticollision or RF reset, stops once mode found.
// - mode detector restarts after every RF reset.
// - CRC-done flag sets when the CRC command has processed all data.
// - field-on flag sets when an external field appears.
// - field-off flag sets when a present external field disappears.
// - polarity-invert 1 puts the inverse of combined status on the pin.
// - primary enable bits 6..0 gate the seven primary flags.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
module tif_irq_top (
  input  wire logic                         clk_i,
  input  wire logic                         resetn_i,
  // AXI4-Lite register port
  input  wire logic [tif_pkg::ADDR_W-1:0]   s_axil_awaddr_i,
  input  wire logic                         s_axil_awvalid_i,
  output logic                              s_axil_awready_o,
  input  wire logic [31:0]                  s_axil_wdata_i,
  input  wire logic [3:0]                   s_axil_wstrb_i,
  input  wire logic                         s_axil_wvalid_i,
  output logic                              s_axil_wready_o,
  output logic [1:0]                        s_axil_bresp_o,
  output logic                              s_axil_bvalid_o,
  input  wire logic                         s_axil_bready_i,
  input  wire logic [tif_pkg::ADDR_W-1:0]   s_axil_araddr_i,
  input  wire logic                         s_axil_arvalid_i,
  output logic                              s_axil_arready_o,
  output logic [31:0]                       s_axil_rdata_o,
  output logic [1:0]                        s_axil_rresp_o,
  output logic                              s_axil_rvalid_o,
  input  wire logic                         s_axil_rready_i,
  // event sources
  input  wire logic                         tx_last_bit_i,
  input  wire logic                         rx_stream_end_i,
  input  wire logic                         receive_no_error_filter_i,
  input  wire logic                         rx_buffer_has_data_i,
  input  wire logic                         cmd_self_done_i,
  input  wire logic                         cmd_unknown_start_i,
  input  wire logic                         buffer_high_level_i,
  input  wire logic                         buffer_low_level_i,
  input  wire logic [tif_pkg::ERR_W-1:0]    error_status_i,
  input  wire logic [tif_pkg::TIMER_W-1:0]  timer_count_i,
  input  wire logic                         secure_input_line_i,
  input  wire logic                         auto_anticollision_command_i,
  input  wire logic                         mode_found_i,
  input  wire logic                         rf_reset_i,
  input  wire logic                         crc_active_i,
  input  wire logic                         crc_data_done_i,
  input  wire logic                         field_present_i,
  // outputs
  output logic                              cmd_force_idle_o,
  output logic                              mode_detect_active_o,
  output logic                              irq_pin_o,
  output logic                              irq_pin_oe_o
);

  tif_reg_if rif ();

  tif_axil_slave u_slave (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .awaddr_i  (s_axil_awaddr_i),
    .awvalid_i (s_axil_awvalid_i),
    .awready_o (s_axil_awready_o),
    .wdata_i   (s_axil_wdata_i),
    .wstrb_i   (s_axil_wstrb_i),
    .wvalid_i  (s_axil_wvalid_i),
    .wready_o  (s_axil_wready_o),
    .bresp_o   (s_axil_bresp_o),
    .bvalid_o  (s_axil_bvalid_o),
    .bready_i  (s_axil_bready_i),
    .araddr_i  (s_axil_araddr_i),
    .arvalid_i (s_axil_arvalid_i),
    .arready_o (s_axil_arready_o),
    .rdata_o   (s_axil_rdata_o),
    .rresp_o   (s_axil_rresp_o),
    .rvalid_o  (s_axil_rvalid_o),
    .rready_i  (s_axil_rready_i),
    .rif       (rif.bus)
  );

  // edge detection on levels
  logic [tif_pkg::EDGE_N-1:0] lvl, rise, fall;

  assign lvl[tif_pkg::E_SECURE] = secure_input_line_i;
  assign lvl[tif_pkg::E_HIGH]   = buffer_high_level_i;
  assign lvl[tif_pkg::E_LOW]    = buffer_low_level_i;
  assign lvl[tif_pkg::E_TZERO]  = (timer_count_i == 16'h0000);
  assign lvl[tif_pkg::E_FIELD]  = field_present_i;

  tif_edge_detect u_edge (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .level_i  (lvl),
    .rise_o   (rise),
    .fall_o   (fall)
  );

  // registers
  logic [tif_pkg::REG_W-1:0]     pri_en_q, pri_en_d;
  logic [tif_pkg::REG_W-1:0]     sec_en_q, sec_en_d;
  logic [tif_pkg::PRI_FLAGS-1:0] pri_req_q, pri_req_d;
  logic [tif_pkg::SEC_FLAGS-1:0] sec_req_q, sec_req_d;
  logic                          mode_act_q, mode_act_d;
  logic                          force_idle_q, force_idle_d;
  logic                          irq_pin_q, irq_pin_d;
  logic                          irq_oe_q, irq_oe_d;

  logic [tif_pkg::PRI_FLAGS-1:0] pri_hw_set;
  logic [tif_pkg::SEC_FLAGS-1:0] sec_hw_set;
  logic                          wr_pri_en, wr_sec_en, wr_pri_req, wr_sec_req;
  logic                          irq_comb, pin_level;

  assign wr_pri_en  = rif.wr_en && (rif.wr_idx == tif_pkg::PRI_EN_IDX);
  assign wr_sec_en  = rif.wr_en && (rif.wr_idx == tif_pkg::SEC_EN_IDX);
  assign wr_pri_req = rif.wr_en && (rif.wr_idx == tif_pkg::PRI_REQ_IDX);
  assign wr_sec_req = rif.wr_en && (rif.wr_idx == tif_pkg::SEC_REQ_IDX);

  // hardware set terms of the primary flags
  always_comb begin
    pri_hw_set                   = 7'h00;
    pri_hw_set[tif_pkg::F_TX]    = tx_last_bit_i;
    pri_hw_set[tif_pkg::F_RX]    = rx_stream_end_i
                                   && (!receive_no_error_filter_i
                                       || rx_buffer_has_data_i);
    // a host-issued idle command drives neither input, so it never sets the flag
    pri_hw_set[tif_pkg::F_IDLE]  = cmd_self_done_i || cmd_unknown_start_i;
    pri_hw_set[tif_pkg::F_HIGH]  = rise[tif_pkg::E_HIGH];
    pri_hw_set[tif_pkg::F_LOW]   = rise[tif_pkg::E_LOW];
    pri_hw_set[tif_pkg::F_ERR]   = |error_status_i;
    pri_hw_set[tif_pkg::F_TIMER] = rise[tif_pkg::E_TZERO];
  end

  // hardware set terms of the secondary flags
  always_comb begin
    sec_hw_set                    = 5'h00;
    sec_hw_set[tif_pkg::F_SECURE] = rise[tif_pkg::E_SECURE]
                                    || fall[tif_pkg::E_SECURE];
    sec_hw_set[tif_pkg::F_MODE]   = mode_act_q && mode_found_i;
    sec_hw_set[tif_pkg::F_CRC]    = crc_active_i && crc_data_done_i;
    sec_hw_set[tif_pkg::F_FON]    = rise[tif_pkg::E_FIELD];
    sec_hw_set[tif_pkg::F_FOFF]   = fall[tif_pkg::E_FIELD];
  end

  // register writes and flag updates; a hardware set in the clearing cycle wins
  always_comb begin
    pri_en_d  = pri_en_q;
    sec_en_d  = sec_en_q;
    pri_req_d = pri_req_q;
    sec_req_d = sec_req_q;
    if (wr_pri_en) begin
      pri_en_d = rif.wr_data;
    end
    if (wr_sec_en) begin
      sec_en_d = rif.wr_data & tif_pkg::SEC_EN_MASK;
    end
    if (wr_pri_req) begin
      if (rif.wr_data[tif_pkg::SEL_BIT]) begin
        pri_req_d = pri_req_q | rif.wr_data[tif_pkg::PRI_FLAGS-1:0];
      end else begin
        pri_req_d = pri_req_q & ~rif.wr_data[tif_pkg::PRI_FLAGS-1:0];
      end
    end
    if (wr_sec_req) begin
      if (rif.wr_data[tif_pkg::SEL_BIT]) begin
        sec_req_d = sec_req_q | rif.wr_data[tif_pkg::SEC_FLAGS-1:0];
      end else begin
        sec_req_d = sec_req_q & ~rif.wr_data[tif_pkg::SEC_FLAGS-1:0];
      end
    end
    pri_req_d = pri_req_d | pri_hw_set;
    sec_req_d = sec_req_d | sec_hw_set;
  end

  // data mode detector run state and command abort pulse
  always_comb begin
    mode_act_d = mode_act_q;
    if (mode_act_q && mode_found_i) begin
      mode_act_d = 1'b0;
    end
    if (auto_anticollision_command_i || rf_reset_i) begin
      mode_act_d = 1'b1;
    end
    force_idle_d = cmd_unknown_start_i;
  end

  // combined status and pin drive
  always_comb begin
    irq_comb  = |(pri_req_q & pri_en_q[tif_pkg::PRI_FLAGS-1:0])
                || |(sec_req_q & sec_en_q[tif_pkg::SEC_FLAGS-1:0]);
    pin_level = irq_comb ^ pri_en_q[tif_pkg::SEL_BIT];
    if (sec_en_q[tif_pkg::SEL_BIT]) begin
      irq_pin_d = pin_level;
      irq_oe_d  = 1'b1;
    end else begin
      // open drain: pull low for a low level, release for a high one
      irq_pin_d = 1'b0;
      irq_oe_d  = !pin_level;
    end
  end

  // read decode; request select bits and reserved bits read as zero
  always_comb begin
    rif.rd_data = 8'h00;
    rif.rd_hit  = 1'b1;
    unique case (rif.rd_idx)
      tif_pkg::PRI_EN_IDX:  rif.rd_data = pri_en_q;
      tif_pkg::SEC_EN_IDX:  rif.rd_data = sec_en_q;
      tif_pkg::PRI_REQ_IDX: rif.rd_data = {1'b0, pri_req_q};
      tif_pkg::SEC_REQ_IDX: rif.rd_data = {3'h0, sec_req_q};
      tif_pkg::STATUS_IDX: begin
        rif.rd_data[tif_pkg::ST_IRQ]      = irq_comb;
        rif.rd_data[tif_pkg::ST_MODE_ACT] = mode_act_q;
        rif.rd_data[tif_pkg::ST_FIELD]    = field_present_i;
      end
      default:              rif.rd_hit  = 1'b0;
    endcase
  end

  always_comb begin
    unique case (rif.wr_idx)
      tif_pkg::PRI_EN_IDX,
      tif_pkg::SEC_EN_IDX,
      tif_pkg::PRI_REQ_IDX,
      tif_pkg::SEC_REQ_IDX: rif.wr_hit = 1'b1;
      default:              rif.wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pri_en_q     <= tif_pkg::PRI_EN_RST;
      sec_en_q     <= tif_pkg::SEC_EN_RST;
      pri_req_q    <= tif_pkg::PRI_REQ_RST[tif_pkg::PRI_FLAGS-1:0];
      sec_req_q    <= tif_pkg::SEC_REQ_RST[tif_pkg::SEC_FLAGS-1:0];
      mode_act_q   <= 1'b0;
      force_idle_q <= 1'b0;
      irq_pin_q    <= 1'b0;
      irq_oe_q     <= 1'b0;
    end else begin
      pri_en_q     <= pri_en_d;
      sec_en_q     <= sec_en_d;
      pri_req_q    <= pri_req_d;
      sec_req_q    <= sec_req_d;
      mode_act_q   <= mode_act_d;
      force_idle_q <= force_idle_d;
      irq_pin_q    <= irq_pin_d;
      irq_oe_q     <= irq_oe_d;
    end
  end

  assign cmd_force_idle_o     = force_idle_q;
  assign mode_detect_active_o = mode_act_q;
  assign irq_pin_o            = irq_pin_q;
  assign irq_pin_oe_o         = irq_oe_q;

endmodule // tif_irq_top

// ### tb/tif_irq_assertions.sv
// checker of the interrupt flag block, bound to its top module
// assumes one clock domain and the active-low reset of the top
`timescale 1ns/10ps
module tif_irq_assertions (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cmd_unknown_start_i,
  input wire logic cmd_force_idle_o,
  input wire logic auto_anticollision_command_i,
  input wire logic rf_reset_i,
  input wire logic mode_found_i,
  input wire logic mode_detect_active_o,
  input wire logic irq_pin_o,
  input wire logic irq_pin_oe_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_od_pin_low: assert property (!irq_pin_oe_o |-> !irq_pin_o)
    else $error("released pin is not low");
  a_idle_forced: assert property (cmd_unknown_start_i |=> cmd_force_idle_o)
    else $error("unknown command not forced to idle");
  a_idle_quiet: assert property (!cmd_unknown_start_i |=> !cmd_force_idle_o)
    else $error("idle forced without cause");
  a_mode_start: assert property (auto_anticollision_command_i |=> mode_detect_active_o)
    else $error("detector not started");
  a_mode_restart: assert property (rf_reset_i |=> mode_detect_active_o)
    else $error("detector not restarted");
  a_mode_stop: assert property (
    mode_found_i && !auto_anticollision_command_i && !rf_reset_i |=> !mode_detect_active_o)
    else $error("detector kept running");
  a_mode_hold: assert property (
    mode_detect_active_o && !mode_found_i |=> mode_detect_active_o)
    else $error("detector stopped early");
  a_mode_origin: assert property ($rose(mode_detect_active_o)
    |-> $past(auto_anticollision_command_i) || $past(rf_reset_i))
    else $error("detector started by itself");

  c_idle: cover property (cmd_force_idle_o);
  c_pin_high: cover property (irq_pin_oe_o && irq_pin_o);
  c_mode_end: cover property ($fell(mode_detect_active_o));
endmodule // tif_irq_assertions

bind tif_irq_top tif_irq_assertions tif_irq_assertions_i (
  .clk_i(clk_i), .resetn_i(resetn_i), .cmd_unknown_start_i(cmd_unknown_start_i),
  .cmd_force_idle_o(cmd_force_idle_o), .rf_reset_i(rf_reset_i), .mode_found_i(mode_found_i),
  .auto_anticollision_command_i(auto_anticollision_command_i),
  .mode_detect_active_o(mode_detect_active_o), .irq_pin_o(irq_pin_o),
  .irq_pin_oe_o(irq_pin_oe_o));

// ### tb/tif_host_model.sv
// host side of the interrupt pin
// assumes the device drives the pin only while its enable is high
`timescale 1ns/10ps
module tif_host_model (
  input  wire logic irq_pin_o,
  input  wire logic irq_pin_oe_o,
  output logic      irq_seen_o
);
  // a released pin rises to the pull-up level
  assign irq_seen_o = irq_pin_oe_o ? irq_pin_o : 1'h1;
endmodule // tif_host_model

// ### tb/tb_top.sv
// bench of the interrupt flag block: register tasks, event pulses, pin checks
// assumes answers within 50 cycles
`timescale 1ns/10ps
module tb_top;
  logic        clk_i = 1'h0;
  logic        resetn_i = 1'h0;
  logic [7:0]  aa = 8'h00, ra = 8'h00;
  logic [31:0] wd = 32'h0, rdt, d;
  logic        av = 1'h0, wv = 1'h0, br = 1'h0, rav = 1'h0, rr = 1'h0;
  logic [11:0] ev = 12'h000;
  logic        flt = 1'h0, hd = 1'h0, sec = 1'h0, fp = 1'h0, ca = 1'h0;
  logic        ar, wr_, bv, arr, rv, pin, oe, mact, seen;
  logic [1:0]  bre, rre, r;
  int          err_count = 0;
  int          total_checks = 0;
  always #25 clk_i = ~clk_i;
  tif_irq_top tif_irq_top_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .s_axil_awaddr_i(aa), .s_axil_awvalid_i(av), .s_axil_awready_o(ar),
    .s_axil_wdata_i(wd), .s_axil_wstrb_i(4'hF), .s_axil_wvalid_i(wv), .s_axil_wready_o(wr_),
    .s_axil_bresp_o(bre), .s_axil_bvalid_o(bv), .s_axil_bready_i(br),
    .s_axil_araddr_i(ra), .s_axil_arvalid_i(rav), .s_axil_arready_o(arr),
    .s_axil_rdata_o(rdt), .s_axil_rresp_o(rre), .s_axil_rvalid_o(rv), .s_axil_rready_i(rr),
    .tx_last_bit_i(ev[6]), .rx_stream_end_i(ev[5]), .receive_no_error_filter_i(flt),
    .rx_buffer_has_data_i(hd), .cmd_self_done_i(ev[4]), .cmd_unknown_start_i(ev[7]),
    .buffer_high_level_i(ev[3]), .buffer_low_level_i(ev[2]), .error_status_i({7'h00, ev[1]}),
    .timer_count_i(ev[0] ? 16'h0000 : 16'h0005), .secure_input_line_i(sec),
    .auto_anticollision_command_i(ev[11]), .mode_found_i(ev[9]), .rf_reset_i(ev[10]),
    .crc_active_i(ca), .crc_data_done_i(ev[8]), .field_present_i(fp),
    .cmd_force_idle_o(), .mode_detect_active_o(mact), .irq_pin_o(pin), .irq_pin_oe_o(oe));
  tif_host_model tif_host_model_i (.irq_pin_o(pin), .irq_pin_oe_o(oe), .irq_seen_o(seen));
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wait_bus(input int n);
    if (n >= 50) begin
      err_count++;
      stop_test();
    end
  endtask
  task automatic wrt(input logic [7:0] a, input logic [7:0] v);
    int n;
    n = 0;
    aa <= a;
    wd <= {24'h000000, v};
    av <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    do begin
      @(posedge clk_i);
      n++;
      if (ar) av <= 1'h0;
      if (wr_) wv <= 1'h0;
    end while (bv !== 1'h1 && n < 50);
    r = bre;
    br <= 1'h0;
    @(posedge clk_i);
    wait_bus(n);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    ra <= a;
    rav <= 1'h1;
    rr <= 1'h1;
    do begin
      @(posedge clk_i);
      n++;
      if (arr) rav <= 1'h0;
    end while (rv !== 1'h1 && n < 50);
    d = rdt;
    r = rre;
    rr <= 1'h0;
    @(posedge clk_i);
    wait_bus(n);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(d, {24'h000000, e});
  endtask
  task automatic pulse(input int b);
    ev <= 12'h001 << b;
    @(posedge clk_i);
    ev <= 12'h000;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic sc(input logic [7:0] e);
    repeat (2) @(posedge clk_i);
    rc(8'h14, e);
    wrt(8'h14, 8'h1F);
  endtask
  task automatic pk(input logic [2:0] e);
    repeat (2) @(posedge clk_i);
    chk({29'h0, seen, oe, pin}, {29'h0, e});
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'h1;
    @(posedge clk_i);
    rc(8'h08, 8'h80);
    rc(8'h0C, 8'h00);
    rc(8'h10, 8'h14);
    rc(8'h14, 8'h00);
    chk({30'h0, r}, 32'h0);
    rd(8'h3C);
    chk({30'h0, r}, 32'h2);
    wrt(8'h3C, 8'h55);
    chk({30'h0, r}, 32'h2);
    pk(3'h4);
    wrt(8'h0C, 8'hFF);
    chk({30'h0, r}, 32'h0);
    rc(8'h0C, 8'h9F);
    wrt(8'h10, 8'hE0);
    rc(8'h10, 8'h74);
    wrt(8'h10, 8'h20);
    rc(8'h10, 8'h54);
    wrt(8'h14, 8'h9B);
    rc(8'h14, 8'h1B);
    wrt(8'h14, 8'h11);
    rc(8'h14, 8'h0A);
    wrt(8'h14, 8'h1F);
    for (int i = 0; i < 8; i++) begin
      wrt(8'h10, 8'h7F);
      pulse(i);
      rc(8'h10, (i == 7) ? 8'h10 : 8'h01 << i);
    end
    flt <= 1'h1;
    wrt(8'h10, 8'h7F);
    pulse(5);
    rc(8'h10, 8'h00);
    hd <= 1'h1;
    pulse(5);
    rc(8'h10, 8'h20);
    sec <= 1'h1;
    sc(8'h10);
    sec <= 1'h0;
    sc(8'h10);
    fp <= 1'h1;
    sc(8'h02);
    fp <= 1'h0;
    sc(8'h01);
    ca <= 1'h1;
    pulse(8);
    sc(8'h04);
    pulse(11);
    chk({31'h0, mact}, 32'h1);
    pulse(9);
    sc(8'h08);
    chk({31'h0, mact}, 32'h0);
    pulse(10);
    chk({31'h0, mact}, 32'h1);
    wrt(8'h10, 8'h7F);
    wrt(8'h08, 8'h01);
    wrt(8'h0C, 8'h80);
    wrt(8'h10, 8'h81);
    pk(3'h7);
    wrt(8'h08, 8'h81);
    pk(3'h2);
    wrt(8'h08, 8'h00);
    pk(3'h2);
    wrt(8'h14, 8'h82);
    wrt(8'h0C, 8'h82);
    pk(3'h7);
    rc(8'h40, 8'h03);
    wrt(8'h0C, 8'h02);
    pk(3'h4);
    wrt(8'h0C, 8'h00);
    pk(3'h2);
    stop_test();
  end
endmodule // tb_top
